// ===== design/packet_dma_queue_base_map.sv
// Queue manager base registers, TX channel slots and TX queue addressing
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "pdq_params.svh"
module packet_dma_queue_base_map (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire pdq_pkg::queue_req_s TX_QREQ_IN,
  input wire logic PEND_SECOND_IN,
  output logic [31:0] TX_QADDR_OUT,
  output logic TX_QADDR_VALID_OUT,
  output pdq_pkg::chan_ctrl_s [3:0] TX_CTRL_OUT,
  output pdq_pkg::chan_mode_s [3:0] TX_MODE_OUT
);

  logic [31:0] qm_base_ff [4];
  pdq_pkg::chan_ctrl_s [3:0] ctrl_ff;
  pdq_pkg::chan_mode_s [3:0] mode_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic [31:0] qaddr_ff;
  logic qvalid_ff;
  logic [1:0] mgr_sel;
  logic setup;
  logic wr_access;
  pdq_pkg::decode_s dec;
  logic [31:0] nxt_rdata;
  logic nxt_slverr;

  // Address decode shared by the read and write paths
  function automatic pdq_pkg::decode_s decode(input logic [11:0] addr);
    pdq_pkg::decode_s d;
    logic [11:0] rel;
    d = '0;
    rel = addr - `PDQ_TX_REGION;
    if (addr >= `PDQ_QM_OFFSET &&
        addr < (`PDQ_QM_OFFSET + `PDQ_QM_SPAN)) begin
      d.hit_qm = 1'b1;
      d.qm_idx = addr[3:2];
    end else if (addr >= `PDQ_TX_REGION &&
                 addr < (`PDQ_TX_REGION + `PDQ_SLOT_SPAN)) begin
      d.ch = rel[6:5];
      if ({rel[4:2], 2'b00} == `PDQ_SLOT_A) begin
        d.hit_a = 1'b1;
      end else if ({rel[4:2], 2'b00} == `PDQ_SLOT_B) begin
        d.hit_b = 1'b1;
      end else begin
        d.hit_rsv = 1'b1;
      end
    end
    return d;
  endfunction

  // Bus phase qualifiers
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr_access = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign dec = decode(PADDR_IN);

  // Zero wait states: read data is prepared during setup
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = rdata_ff;
  assign PSLVERR_OUT = slverr_ff;

  // Read mux; reserved slot words answer zero without error
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_slverr = 1'b0;
    if (dec.hit_qm) begin
      nxt_rdata = qm_base_ff[dec.qm_idx];
    end else if (dec.hit_a) begin
      nxt_rdata[`PDQ_TXA_ENABLE] = ctrl_ff[dec.ch].enable;
      nxt_rdata[`PDQ_TXA_TEARDOWN] = ctrl_ff[dec.ch].teardown;
      nxt_rdata[`PDQ_TXA_PAUSE] = ctrl_ff[dec.ch].pause;
    end else if (dec.hit_b || dec.hit_rsv) begin
      nxt_rdata = 32'h00000000;
    end else begin
      nxt_slverr = 1'b1;
    end
  end

  // Read data and error flag captured at setup, held through access
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      rdata_ff <= PWRITE_IN ? 32'h00000000 : nxt_rdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // Logical manager base registers
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      qm_base_ff[0] <= `PDQ_QM0_RESET;
      qm_base_ff[1] <= `PDQ_QMX_RESET;
      qm_base_ff[2] <= `PDQ_QMX_RESET;
      qm_base_ff[3] <= `PDQ_QMX_RESET;
    end else if (wr_access && dec.hit_qm) begin
      qm_base_ff[dec.qm_idx] <= PWDATA_IN;
    end
  end

  // Channel slot registers; reserved words fall through untouched
  generate
    for (genvar c = 0; c < `PDQ_TX_CHANNELS; c++) begin : g_chan
      always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          ctrl_ff[c] <= '0;
          mode_ff[c] <= '0;
        end else if (wr_access && dec.ch == 2'(c)) begin
          if (dec.hit_a) begin
            ctrl_ff[c].enable <= PWDATA_IN[`PDQ_TXA_ENABLE];
            ctrl_ff[c].teardown <= PWDATA_IN[`PDQ_TXA_TEARDOWN];
            ctrl_ff[c].pause <= PWDATA_IN[`PDQ_TXA_PAUSE];
          end
          // Mode bits are write only; change them only while disabled (writes here land whatever the enable bit holds)
          if (dec.hit_b) begin
            mode_ff[c].filt_einfo <= PWDATA_IN[`PDQ_TXB_EINFO];
            mode_ff[c].filt_pswords <= PWDATA_IN[`PDQ_TXB_PSWORDS];
            mode_ff[c].aif_mono <= PWDATA_IN[`PDQ_TXB_MONO];
          end
        end
      end
    end
  endgenerate

  assign TX_CTRL_OUT = ctrl_ff;
  assign TX_MODE_OUT = mode_ff;

  // Pend source picks logical zero or logical two
  assign mgr_sel = PEND_SECOND_IN ? `PDQ_MGR_TWO : `PDQ_MGR_ZERO;

  // Queue address is base plus sixteen bytes per queue
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      qaddr_ff <= 32'h00000000;
      qvalid_ff <= 1'b0;
    end else begin
      qvalid_ff <= TX_QREQ_IN.valid;
      if (TX_QREQ_IN.valid) begin
        qaddr_ff <= qm_base_ff[mgr_sel] + 32'({TX_QREQ_IN.qnum,
                    4'h0});
      end
    end
  end

  assign TX_QADDR_OUT = qaddr_ff;
  assign TX_QADDR_VALID_OUT = qvalid_ff;

  // Checks on the design's own registers and outputs
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_setup_read;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  endsequence

  sequence s_setup_write;
    PSEL_IN && !PENABLE_IN && PWRITE_IN;
  endsequence

  AST_RESET_VALUES: assert property (
    $rose(RESETN_IN) |-> qm_base_ff[0] == `PDQ_QM0_RESET &&
      qm_base_ff[1] == 32'h0 && qm_base_ff[2] == 32'h0 &&
      qm_base_ff[3] == 32'h0)
    else $error("base register reset value wrong");

  AST_QM_WRITE: assert property (
    wr_access && dec.hit_qm |=>
      qm_base_ff[$past(dec.qm_idx)] == $past(PWDATA_IN))
    else $error("base register write lost");

  AST_QM_READ: assert property (
    s_setup_read ##0 dec.hit_qm |=>
      PRDATA_OUT == qm_base_ff[$past(PADDR_IN[3:2])] && !PSLVERR_OUT)
    else $error("base register read wrong");

  AST_QADDR: assert property (
    TX_QREQ_IN.valid |=> TX_QADDR_VALID_OUT &&
      TX_QADDR_OUT == $past(qm_base_ff[mgr_sel]) +
      {16'h0, $past(TX_QREQ_IN.qnum), 4'h0})
    else $error("queue address wrong");

  AST_MGR_SEL: assert property (
    TX_QREQ_IN.valid && PEND_SECOND_IN && !(wr_access && dec.hit_qm)
      |=> TX_QADDR_OUT[3:0] == qm_base_ff[2][3:0] &&
      TX_QADDR_OUT - {16'h0, $past(TX_QREQ_IN.qnum), 4'h0} ==
      qm_base_ff[2])
    else $error("second pend source not on logical two");

  AST_RSV_READ: assert property (
    s_setup_read ##0 dec.hit_rsv |=> PRDATA_OUT == 32'h0 &&
      !PSLVERR_OUT)
    else $error("reserved slot word not zero");

  AST_RSV_WRITE: assert property (
    s_setup_write ##1 (wr_access && dec.hit_rsv) |=>
      $stable(ctrl_ff) && $stable(mode_ff))
    else $error("reserved slot write changed a channel");

  AST_SLOT_A: assert property (
    wr_access && dec.hit_a |=>
      ctrl_ff[$past(dec.ch)].enable == $past(PWDATA_IN[31]) &&
      ctrl_ff[$past(dec.ch)].pause == $past(PWDATA_IN[29]))
    else $error("slot register A write lost");

  AST_UNMAPPED: assert property (
    s_setup_read ##0 !(dec.hit_qm || dec.hit_a || dec.hit_b ||
      dec.hit_rsv) |=> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped read not flagged");

  // Single-cycle bus and queue views used by the guards below
  sequence s_access_write;
    PSEL_IN && PENABLE_IN && PWRITE_IN;
  endsequence

  sequence s_qreq_first;
    TX_QREQ_IN.valid && !PEND_SECOND_IN;
  endsequence

  AST_MGR_ZERO: assert property (
    s_qreq_first ##0 !(wr_access && dec.hit_qm) |=>
      TX_QADDR_OUT - {16'h0, $past(TX_QREQ_IN.qnum), 4'h0} ==
      qm_base_ff[0])
    else $error("first pend source not on logical zero");

  AST_QVALID_IDLE: assert property (
    !TX_QREQ_IN.valid |=> !TX_QADDR_VALID_OUT)
    else $error("queue address valid without request");

  // Downstream may sample the address late, so it must hold
  AST_QADDR_HOLD: assert property (
    !TX_QREQ_IN.valid |=> $stable(TX_QADDR_OUT))
    else $error("queue address moved without request");

  AST_QM_HOLD: assert property (
    !(wr_access && dec.hit_qm) |=> $stable(qm_base_ff[0]) &&
      $stable(qm_base_ff[1]) && $stable(qm_base_ff[2]) &&
      $stable(qm_base_ff[3]))
    else $error("base register changed without write");

  AST_SLOT_B: assert property (
    s_access_write ##0 dec.hit_b |=>
      mode_ff[$past(dec.ch)].filt_einfo == $past(PWDATA_IN[30]) &&
      mode_ff[$past(dec.ch)].aif_mono == $past(PWDATA_IN[24]))
    else $error("slot register B write lost");

  AST_TEARDOWN: assert property (
    wr_access && dec.hit_a |=>
      ctrl_ff[$past(dec.ch)].teardown == $past(PWDATA_IN[30]))
    else $error("teardown bit write lost");

  // Register B is write only, so reads must not leak mode bits
  AST_B_READ: assert property (
    s_setup_read ##0 dec.hit_b |=> PRDATA_OUT == 32'h0 &&
      !PSLVERR_OUT)
    else $error("slot register B read not zero");

  AST_A_READ: assert property (
    s_setup_read ##0 dec.hit_a |=> PRDATA_OUT[28:0] == 29'h0 &&
      PRDATA_OUT[31] == ctrl_ff[$past(dec.ch)].enable)
    else $error("slot register A read wrong");

  AST_RDATA_STANDS: assert property (
    !setup |=> $stable(PRDATA_OUT) && $stable(PSLVERR_OUT))
    else $error("read data moved outside setup");

  AST_WRITE_RDATA: assert property (
    s_setup_write |=> PRDATA_OUT == 32'h0)
    else $error("read data not cleared on write");

  AST_RSV_QM: assert property (
    wr_access && dec.hit_rsv |=> $stable(qm_base_ff[0]) &&
      $stable(qm_base_ff[1]) && $stable(qm_base_ff[2]) &&
      $stable(qm_base_ff[3]))
    else $error("reserved slot write changed a base");

  AST_QM_NO_ERR: assert property (
    s_setup_write ##0 dec.hit_qm |=> !PSLVERR_OUT)
    else $error("base register write flagged");

  // First cycle after reset must not carry a stale request
  AST_RESET_OUTPUTS: assert property (
    $rose(RESETN_IN) |-> !TX_QADDR_VALID_OUT &&
      TX_QADDR_OUT == 32'h0)
    else $error("queue output not clear after reset");

endmodule

// ===== inc/pdq_params.svh
// Offsets, field positions, reset values and sizes of the queue base map
// Behaviour
// - Four read/write 32-bit registers hold each logical manager's base address.
// - Reset loads manager zero with 0x34020000; managers one to three clear.
// - TX queue bus addresses are built from one logical manager base.
// - Pend source first manager uses logical zero; second uses logical two.
// - Each TX channel has a 32-byte slot: register A at 0x000, B at 0x004.
// - Slot offsets 0x008 to 0x01F are reserved, holding no channel registers.
// - Base registers sit at global offsets 0x10, 0x14, 0x18 and 0x1c.
`ifndef PDQ_PARAMS_SVH
`define PDQ_PARAMS_SVH
`define PDQ_ADDR_W 12
`define PDQ_QM_COUNT 4
`define PDQ_QM_OFFSET 12'h010
`define PDQ_QM_SPAN 12'h010
`define PDQ_QM0_RESET 32'h34020000
`define PDQ_QMX_RESET 32'h00000000
`define PDQ_TX_REGION 12'h400
`define PDQ_TX_CHANNELS 4
`define PDQ_SLOT_SPAN 12'h080
`define PDQ_SLOT_A 5'h00
`define PDQ_SLOT_B 5'h04
`define PDQ_TXA_ENABLE 31
`define PDQ_TXA_TEARDOWN 30
`define PDQ_TXA_PAUSE 29
`define PDQ_TXB_EINFO 30
`define PDQ_TXB_PSWORDS 29
`define PDQ_TXB_MONO 24
`define PDQ_QNUM_W 12
`define PDQ_QUEUE_SHIFT 4
`define PDQ_MGR_ZERO 2'h0
`define PDQ_MGR_TWO 2'h2
`endif

// ===== inc/pdq_pkg.sv
// Types shared by the queue base map
package pdq_pkg;
  typedef struct packed {
    logic valid;
    logic [11:0] qnum;
  } queue_req_s;
  typedef struct packed {
    logic enable;
    logic teardown;
    logic pause;
  } chan_ctrl_s;
  typedef struct packed {
    logic filt_einfo;
    logic filt_pswords;
    logic aif_mono;
  } chan_mode_s;
  typedef struct packed {
    logic hit_qm;
    logic [1:0] qm_idx;
    logic hit_a;
    logic hit_b;
    logic hit_rsv;
    logic [1:0] ch;
  } decode_s;
endpackage

// ===== sim/packet_dma_queue_base_map_tb_top.sv
// Self-checking bench for the queue base map
`timescale 1ns/1ns
module packet_dma_queue_base_map_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  pdq_pkg::queue_req_s qreq = '0;
  logic pend = 1'b0;
  wire [31:0] prdata;
  wire [31:0] qaddr;
  wire [31:0] last;
  wire [15:0] hits;
  wire pready;
  wire pslverr;
  wire qvalid;
  pdq_pkg::chan_ctrl_s [3:0] ctrl;
  pdq_pkg::chan_mode_s [3:0] mode;
  integer seed = 32'h1C27;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] base [4];
  logic [31:0] rd, w, ebase;
  logic [11:0] eq;
  logic err;
  logic [11:0] bad [3] = '{12'h00C, 12'h020, 12'h480};

  // 50 MHz clock
  always #10 clk = ~clk;

  packet_dma_queue_base_map i_dut (.CLOCK_IN(clk), .RESETN_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TX_QREQ_IN(qreq), .PEND_SECOND_IN(pend),
    .TX_QADDR_OUT(qaddr), .TX_QADDR_VALID_OUT(qvalid),
    .TX_CTRL_OUT(ctrl), .TX_MODE_OUT(mode));

  pdq_qm_model i_qm (.clk_in(clk), .rst_n_in(rst_n), .addr_in(qaddr),
    .valid_in(qvalid), .last_out(last), .hits_out(hits));

  task summarize;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready with a bound
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h010 + 12'(4 * i), 32'h0);
      chk(rd, i == 0 ? 32'h34020000 : 32'h00000000);
      chk({31'h0, err}, 32'h0);
      w = $random(seed);
      base[i] = w;
      apb(1'b1, 12'h010 + 12'(4 * i), w);
      apb(1'b0, 12'h010 + 12'(4 * i), 32'h0);
      chk(rd, w);
    end
    // Usual software setup for manager one
    base[1] = 32'h34030000;
    apb(1'b1, 12'h014, base[1]);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h34030000);
    foreach (bad[k]) begin
      apb(1'b0, bad[k], 32'h0);
      chk({rd[30:0], err}, 32'h1);
    end
    for (int c = 0; c < 4; c++) begin
      w = $random(seed);
      apb(1'b1, 12'h400 + 12'(32 * c), w);
      chk({29'h0, ctrl[c]}, {29'h0, w[31:29]});
      apb(1'b0, 12'h400 + 12'(32 * c), 32'h0);
      chk(rd, w & 32'hE0000000);
      apb(1'b1, 12'h404 + 12'(32 * c), ~w);
      chk({29'h0, mode[c]}, {29'h0, ~w[30], ~w[29], ~w[24]});
      for (int r = 4; r < 32; r += 4) begin
        if (r > 4) apb(1'b1, 12'h400 + 12'(32 * c + r), 32'hFFFFFFFF);
        apb(1'b0, 12'h400 + 12'(32 * c + r), 32'h0);
        chk(rd | {31'h0, err}, 32'h0);
      end
      chk({29'h0, ctrl[c]}, {29'h0, w[31:29]});
    end
    // Back-to-back queue requests, random source manager
    for (int k = 0; k <= 8; k++) begin
      @(posedge clk);
      qreq <= {k < 8, 12'($random(seed))};
      pend <= 1'($random(seed));
      #1;
      if (k > 0) begin
        chk({31'h0, qvalid}, 32'h1);
        chk(qaddr, ebase + {16'h0, eq, 4'h0});
      end
      ebase = base[pend ? 2 : 0];
      eq = qreq.qnum;
    end
    @(posedge clk);
    #1;
    chk({31'h0, qvalid}, 32'h0);
    chk({16'h0, hits}, 32'h8);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h34020000);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule

// ===== sim/pdq_qm_model.sv
// Queue manager stand-in that records translated TX queue addresses
`timescale 1ns/1ns
module pdq_qm_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] addr_in,
  input wire logic valid_in,
  output logic [31:0] last_out,
  output logic [15:0] hits_out
);
  // Count every pulse so a lost or doubled request shows
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_out <= 32'h00000000;
      hits_out <= 16'h0000;
    end else if (valid_in) begin
      last_out <= addr_in;
      hits_out <= hits_out + 16'h0001;
    end
  end
endmodule
